//--- ulpi_lpm_pkg.sv
// package: shared constants for the ulpi low power and interface protect block
package ulpi_lpm_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] IRQEN_ADDR = 8'h08;
  localparam logic [7:0] IRQST_ADDR = 8'h0C;

  // ------------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------------
  localparam int PHY_ACTIVE_BIT = 0;
  localparam int HOST_MODE_BIT = 1;
  localparam int HS_MODE_BIT = 2;
  localparam int LINE_MODE_LSB = 3;
  localparam int STOP_PULLUP_DIS_BIT = 7;
  localparam logic [1:0] LINE_MODE_HIZ = 2'h1;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  // ------------------------------------------------------------------
  // interrupt status bits
  // ------------------------------------------------------------------
  localparam int HOST_DISC_BIT = 4;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int SUSPEND_EDGES = 5;
  localparam int START_TIME_US = 1;
  localparam int START_CYCLES = START_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_SYNC = 3'h0,
    ST_ENTER = 3'h1,
    ST_LOWPWR = 3'h2,
    ST_START = 3'h3,
    ST_WAIT_STP = 3'h4
  } lpm_state_t;

endpackage : ulpi_lpm_pkg

//--- ulpi_sync2.sv
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module ulpi_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule : ulpi_sync2
`default_nettype wire

//--- ulpi_cmp_irq.sv
// comparator edge detector feeding sticky interrupt status
`timescale 1ns/1ps
`default_nettype none
module ulpi_cmp_irq #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] cmp,
  input wire logic [N-1:0] rise_en,
  input wire logic [N-1:0] fall_en,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] pend
);
  logic [N-1:0] prev_r;
  logic [N-1:0] pend_r;
  logic [N-1:0] pend_nxt;
  always_comb begin
    // set wins over clear so a change in the clearing cycle survives
    pend_nxt = (pend_r & ~clr) | (cmp & ~prev_r & rise_en) | (~cmp & prev_r & fall_en);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= '0;
      pend_r <= '0;
    end else begin
      prev_r <= cmp;
      pend_r <= pend_nxt;
    end
  end
  assign pend = pend_r;
endmodule : ulpi_cmp_irq
`default_nettype wire

//--- ulpi_lpm_top.sv
// top: ulpi low power mode sequencing, interface protection, registers
// ------------------------------------------------------------------
// How it works
// - hs host samples disconnect only in long eop, sends rxcmd, sets status
// - in low power only pins, fs receiver and comparators stay powered
// - line mode 01 puts both data lines in high impedance
// - after clearing write, raise dir, five clock edges, then stop clock
// - in low power data0 is dplus, data1 dminus, bits 2,7-4 low
// - in low power data3 is active high interrupt for unmasked events
// - comparator change with rise or fall enable asserts data3
// - in low power the data bus is re-timed on each MCLK edge while the output clock is stopped
// - link raises stp to leave low power; device starts up
// - after start-up restart clock then drop dir; code restarts clock on entering start-up
// - leaving low power sets phy active bit without a write
// - stp dropped before dir falls is a false resume, back to low power
// - link drives bus while dir low, device while high, one turnaround
// - stp pull-up on at reset; stop pullup disable bit turns it off
// - stp high in low power, from pull-up too, restarts the clock
// ------------------------------------------------------------------
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ulpi_lpm_top #(
  parameter int START_CNT = ulpi_lpm_pkg::START_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // ulpi link pins
  input wire logic STP,
  output logic DIR,
  output logic PHY_CLOCK_OUT,
  output logic [7:0] DATA_O,
  output logic DATA_OE,
  output logic STP_PULLUP_EN,
  // line side
  input wire logic DPLUS_SE,
  input wire logic DMINUS_SE,
  input wire logic LONG_EOP,
  input wire logic DISC_SENSE,
  input wire logic [3:0] CMP_IN,
  output logic LINE_HIZ,
  output logic ANALOG_PWR_EN,
  output logic RXCMD_REQ
);
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [8:0] pins_s;
  ulpi_sync2 #(.W(9)) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d({STP, DPLUS_SE, DMINUS_SE, LONG_EOP, DISC_SENSE, CMP_IN}),
    .q(pins_s)
  );
  logic stp_s;
  logic dp_s;
  logic dm_s;
  logic eop_s;
  logic disc_s;
  logic [3:0] cmp_s;
  assign {stp_s, dp_s, dm_s, eop_s, disc_s, cmp_s} = pins_s;

  // ------------------------------------------------------------------
  // ahb-lite address phase capture
  // ------------------------------------------------------------------
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic rd_pend_r;
  logic rd_pend_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic take;
  assign take = HSEL && HREADY && HTRANS[1];
  always_comb begin
    wr_pend_nxt = take && HWRITE;
    rd_pend_nxt = take && !HWRITE;
    addr_nxt = take ? HADDR : addr_r;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [3:0] rise_en_r;
  logic [3:0] rise_en_nxt;
  logic [3:0] fall_en_r;
  logic [3:0] fall_en_nxt;
  logic disc_st_r;
  logic disc_st_nxt;
  logic [3:0] cmp_pend;
  logic [3:0] cmp_clr;
  logic [31:0] rdata_nxt;
  logic wr_ctrl;
  logic wr_irqen;
  logic wr_irqst;
  logic disc_evt;
  logic leave_lp;
  logic phy_active;
  assign phy_active = ctrl_r[ulpi_lpm_pkg::PHY_ACTIVE_BIT];

  ulpi_cmp_irq #(.N(4)) u_irq (
    .clk(MCLK),
    .rst(RST),
    .cmp(cmp_s),
    .rise_en(rise_en_r),
    .fall_en(fall_en_r),
    .clr(cmp_clr),
    .pend(cmp_pend)
  );

  // ------------------------------------------------------------------
  // low power sequencer
  // ------------------------------------------------------------------
  ulpi_lpm_pkg::lpm_state_t state_r;
  ulpi_lpm_pkg::lpm_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic clk_div_r;
  logic clk_div_nxt;
  logic dir_r;
  logic dir_nxt;
  logic clk_run;

  always_comb begin
    wr_ctrl = wr_pend_r && (addr_r == ulpi_lpm_pkg::CTRL_ADDR);
    wr_irqen = wr_pend_r && (addr_r == ulpi_lpm_pkg::IRQEN_ADDR);
    wr_irqst = wr_pend_r && (addr_r == ulpi_lpm_pkg::IRQST_ADDR);
    // sampling window is the long eop of an hs host frame only
    disc_evt = (state_r == ulpi_lpm_pkg::ST_SYNC) && ctrl_r[ulpi_lpm_pkg::HOST_MODE_BIT]
      && ctrl_r[ulpi_lpm_pkg::HS_MODE_BIT] && eop_s && disc_s;
    leave_lp = (state_r == ulpi_lpm_pkg::ST_WAIT_STP) && !stp_s;
    ctrl_nxt = wr_ctrl ? HWDATA : ctrl_r;
    if (leave_lp) begin
      ctrl_nxt[ulpi_lpm_pkg::PHY_ACTIVE_BIT] = 1'b1;
    end
    rise_en_nxt = wr_irqen ? HWDATA[3:0] : rise_en_r;
    fall_en_nxt = wr_irqen ? HWDATA[11:8] : fall_en_r;
    cmp_clr = wr_irqst ? HWDATA[3:0] : 4'h0;
    disc_st_nxt = disc_evt
      || (disc_st_r && !(wr_irqst && HWDATA[ulpi_lpm_pkg::HOST_DISC_BIT]));
    // decode the address-phase address so read data stands in the data phase
    case (addr_nxt)
      ulpi_lpm_pkg::CTRL_ADDR: rdata_nxt = ctrl_r;
      ulpi_lpm_pkg::STAT_ADDR: rdata_nxt = {26'h0000000, state_r, dir_r, dm_s, dp_s};
      ulpi_lpm_pkg::IRQEN_ADDR: rdata_nxt = {20'h00000, fall_en_r, 4'h0, rise_en_r};
      ulpi_lpm_pkg::IRQST_ADDR: rdata_nxt = {27'h0000000, disc_st_r, cmp_pend};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    case (state_r)
      ulpi_lpm_pkg::ST_SYNC: begin
        dir_nxt = 1'b0;
        // entry starts once the clearing write has completed
        if (!phy_active && !wr_pend_r) begin
          state_nxt = ulpi_lpm_pkg::ST_ENTER;
          dir_nxt = 1'b1;
          cnt_nxt = 16'h0000;
        end
      end
      ulpi_lpm_pkg::ST_ENTER: begin
        // count rising edges of the divided output clock
        if (!clk_div_r) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
        if (cnt_r >= 16'(ulpi_lpm_pkg::SUSPEND_EDGES) && clk_div_r) begin
          state_nxt = ulpi_lpm_pkg::ST_LOWPWR;
        end
      end
      ulpi_lpm_pkg::ST_LOWPWR: begin
        // stp raised by link or pull-up both wake the block
        if (stp_s) begin
          state_nxt = ulpi_lpm_pkg::ST_START;
          cnt_nxt = 16'h0000;
        end
      end
      ulpi_lpm_pkg::ST_START: begin
        if (!stp_s) begin
          state_nxt = ulpi_lpm_pkg::ST_LOWPWR;
        end else if (cnt_r >= 16'(START_CNT)) begin
          state_nxt = ulpi_lpm_pkg::ST_WAIT_STP;
          dir_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ulpi_lpm_pkg::ST_WAIT_STP: begin
        if (!stp_s) begin
          state_nxt = ulpi_lpm_pkg::ST_SYNC;
        end
      end
      default: begin
        state_nxt = ulpi_lpm_pkg::ST_SYNC;
        dir_nxt = 1'b0;
      end
    endcase
    // clock runs except in low power; restarted in start-up before dir drops
    clk_run = (state_r != ulpi_lpm_pkg::ST_LOWPWR);
    clk_div_nxt = clk_run ? !clk_div_r : 1'b0;
  end

  // ------------------------------------------------------------------
  // state registers and registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      ctrl_r <= ulpi_lpm_pkg::CTRL_RESET;
      rise_en_r <= 4'h0;
      fall_en_r <= 4'h0;
      disc_st_r <= 1'b0;
      state_r <= ulpi_lpm_pkg::ST_SYNC;
      cnt_r <= 16'h0000;
      clk_div_r <= 1'b0;
      dir_r <= 1'b0;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      DIR <= 1'b0;
      PHY_CLOCK_OUT <= 1'b0;
      DATA_O <= 8'h00;
      DATA_OE <= 1'b0;
      STP_PULLUP_EN <= 1'b1;
      LINE_HIZ <= 1'b0;
      ANALOG_PWR_EN <= 1'b1;
      RXCMD_REQ <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r <= addr_nxt;
      ctrl_r <= ctrl_nxt;
      rise_en_r <= rise_en_nxt;
      fall_en_r <= fall_en_nxt;
      disc_st_r <= disc_st_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      clk_div_r <= clk_div_nxt;
      dir_r <= dir_nxt;
      HRDATA <= rdata_nxt;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      DIR <= dir_nxt;
      PHY_CLOCK_OUT <= clk_div_nxt;
      // device drives only while dir is high; idle turnaround left to link
      DATA_OE <= dir_r && dir_nxt;
      if (state_nxt == ulpi_lpm_pkg::ST_LOWPWR || state_nxt == ulpi_lpm_pkg::ST_START) begin
        // clock-free path would be combinational; here re-timed each edge
        DATA_O <= {4'h0, |cmp_pend, 1'b0, dm_s, dp_s};
      end else begin
        DATA_O <= 8'h00;
      end
      STP_PULLUP_EN <= !ctrl_nxt[ulpi_lpm_pkg::STOP_PULLUP_DIS_BIT];
      LINE_HIZ <= ctrl_nxt[ulpi_lpm_pkg::LINE_MODE_LSB +: 2] == ulpi_lpm_pkg::LINE_MODE_HIZ;
      ANALOG_PWR_EN <= state_nxt != ulpi_lpm_pkg::ST_LOWPWR;
      RXCMD_REQ <= disc_evt;
    end
  end

endmodule : ulpi_lpm_top
`default_nettype wire

//--- ulpi_lpm_top_assertions.sv
// checker: port-level properties of the low power block
`timescale 1ns/1ps
`default_nettype none
module ulpi_lpm_checker #(
  parameter int START_CNT = 4
) (
  // clock, reset and bus
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  // link and line side
  input wire logic STP,
  input wire logic DIR,
  input wire logic PHY_CLOCK_OUT,
  input wire logic [7:0] DATA_O,
  input wire logic DATA_OE,
  input wire logic STP_PULLUP_EN,
  input wire logic LONG_EOP,
  input wire logic LINE_HIZ,
  input wire logic ANALOG_PWR_EN,
  input wire logic RXCMD_REQ
);
  // ----
  // helpers
  // ----
  logic wr_r;
  logic ck_r;
  logic [7:0] ad_r;
  logic [7:0] wk_r;
  logic [2:0] ed_r;
  wire logic ctrl_wr = wr_r && ad_r == ulpi_lpm_pkg::CTRL_ADDR;
  always_ff @(posedge MCLK) begin
    wr_r <= !RST && HSEL && HREADY && HTRANS[1] && HWRITE;
    ad_r <= HADDR;
    ck_r <= PHY_CLOCK_OUT;
    // clock-out rises since dir rose; saturates so it never wraps
    if (RST || !DIR)
      ed_r <= 3'h0;
    else if (PHY_CLOCK_OUT && !ck_r && ed_r != 3'h7)
      ed_r <= ed_r + 3'h1;
    // cycles with stop high while dir still high
    if (RST || !DIR || !STP)
      wk_r <= 8'h00;
    else if (wk_r != 8'hFF)
      wk_r <= wk_r + 8'h01;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----
  // properties
  // ----
  property p_pullup;
    ctrl_wr |-> ##2 STP_PULLUP_EN == !$past(HWDATA[7], 2);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up off bit ignored");
  property p_hiz;
    ctrl_wr |-> ##2 LINE_HIZ == ($past(HWDATA[4:3], 2) == ulpi_lpm_pkg::LINE_MODE_HIZ);
  endproperty
  a_hiz: assert property (p_hiz) else $error("line hiz wrong");
  property p_edges;
    $fell(ANALOG_PWR_EN) |-> ed_r >= ulpi_lpm_pkg::SUSPEND_EDGES;
  endproperty
  a_edges: assert property (p_edges) else $error("too few clock edges");
  property p_lp_pwr;
    !ANALOG_PWR_EN |-> DIR && !PHY_CLOCK_OUT;
  endproperty
  a_lp_pwr: assert property (p_lp_pwr) else $error("low power state wrong");
  property p_lp_bus;
    !ANALOG_PWR_EN && DATA_OE |-> DATA_O[7:4] == 4'h0 && !DATA_O[2];
  endproperty
  a_lp_bus: assert property (p_lp_bus) else $error("reserved bits driven");
  property p_own;
    DATA_OE |-> $past(DIR);
  endproperty
  a_own: assert property (p_own) else $error("bus driven out of turn");
  property p_disc;
    !LONG_EOP [*6] |-> !RXCMD_REQ;
  endproperty
  a_disc: assert property (p_disc) else $error("rxcmd outside long eop");
  property p_wake;
    wk_r < START_CNT + 16;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on stop");
  property p_false;
    (DIR && !STP) [*5] |=> DIR;
  endproperty
  a_false: assert property (p_false) else $error("dir dropped without stop");
  c_sleep: cover property ($fell(ANALOG_PWR_EN));
  c_wake: cover property ($fell(DIR));
  c_rxcmd: cover property (RXCMD_REQ);
endmodule : ulpi_lpm_checker
`default_nettype wire

//--- ulpi_link_model.sv
// link controller model: stop pin and bus ownership
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench commands
  input wire logic wake,
  input wire logic glitch,
  input wire logic tri_en,
  // ulpi pins
  input wire logic dir,
  output logic stp_o,
  output logic stp_oe,
  output logic data_oe
);
  logic hold_r;
  logic hold_nxt;
  always_comb begin
    hold_nxt = rst || wake || (hold_r && dir);
  end
  always_ff @(posedge clk) begin
    hold_r <= hold_nxt;
    stp_oe <= rst || !tri_en;
    data_oe <= !dir;
  end
  // glitch raises stop briefly so it drops again before dir falls, only when the bench asks
  assign stp_o = hold_r || glitch;
endmodule : ulpi_link_model
`default_nettype wire

//--- ulpi_low_power_and_interface_protect_tb_top.sv
// testbench: low power entry and exit, stop pull-up, disconnect sampling
`timescale 1ns/1ps
`default_nettype none
module ulpi_low_power_and_interface_protect_tb_top;
  logic MCLK = 1'h0;
  logic RST = 1'h1;
  logic HSEL = 1'h0;
  logic HWRITE = 1'h0;
  logic [7:0] HADDR = 8'h00;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h00000000;
  logic DPLUS_SE = 1'h0;
  logic DMINUS_SE = 1'h0;
  logic LONG_EOP = 1'h0;
  logic DISC_SENSE = 1'h0;
  logic [3:0] CMP_IN = 4'h2;
  logic wake = 1'h0;
  logic glitch = 1'h0;
  logic tri_en = 1'h0;
  logic [31:0] HRDATA, rd;
  logic [7:0] DATA_O;
  logic HREADYOUT, HRESP, DIR, PHY_CLOCK_OUT, DATA_OE, STP_PULLUP_EN, LINE_HIZ;
  logic ANALOG_PWR_EN, RXCMD_REQ, stp_o, stp_oe, ck;
  wire logic HREADY = HREADYOUT;
  // undriven with no pull-up: show the inverse of the last level
  wire logic STP = stp_oe ? stp_o : (STP_PULLUP_EN ? 1'h1 : !stp_o);
  int fails = 0;
  int comparisons = 0;
  int edges = 0;
  int n;
  ulpi_lpm_top #(.START_CNT(4)) ulpi_lpm_top_i (.*);
  ulpi_link_model ulpi_link_model_i (.clk(MCLK), .rst(RST), .wake, .glitch, .tri_en,
    .dir(DIR), .stp_o, .stp_oe, .data_oe());
  initial forever #10 MCLK = !MCLK;
  always @(posedge PHY_CLOCK_OUT) edges += int'(DIR === 1'h1);
  // ----
  // tasks
  // ----
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    HSEL <= 1'h1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    @(posedge MCLK iff HREADY === 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge MCLK iff HREADY === 1'h1);
    rd = HRDATA;
  endtask : ahb
  task automatic count_rx(input int k);
    n = 0;
    repeat (k) begin
      @(posedge MCLK);
      n += int'(RXCMD_REQ === 1'h1);
    end
  endtask : count_rx
  task automatic wait_dir_low;
    n = 0;
    while (DIR !== 1'h0 && n < 60) begin
      @(posedge MCLK);
      n++;
    end
  endtask : wait_dir_low
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // ----
  // tests
  // ----
  initial begin
    repeat (3) @(posedge MCLK);
    RST <= 1'h0;
    ahb(1'h0, ulpi_lpm_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl reset", ulpi_lpm_pkg::CTRL_RESET, rd);
    chk("pullup reset", 32'h1, STP_PULLUP_EN);
    chk("hresp", 32'h0, HRESP);
    chk("hreadyout", 32'h1, HREADYOUT);
    ahb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'h1, ulpi_lpm_pkg::CTRL_ADDR, 32'h00000089);
    repeat (2) @(posedge MCLK);
    chk("pullup off", 32'h0, STP_PULLUP_EN);
    chk("line hiz", 32'h1, LINE_HIZ);
    $display("test registers done");
    ahb(1'h1, ulpi_lpm_pkg::CTRL_ADDR, 32'h00000007);
    DISC_SENSE <= 1'h1;
    count_rx(12);
    chk("rxcmd outside eop", 32'h0, n);
    LONG_EOP <= 1'h1;
    @(posedge MCLK);
    LONG_EOP <= 1'h0;
    DISC_SENSE <= 1'h0;
    count_rx(12);
    chk("rxcmd in eop", 32'h1, n > 0);
    ahb(1'h0, ulpi_lpm_pkg::IRQST_ADDR, 32'h0);
    chk("disc status", 32'h1, rd[ulpi_lpm_pkg::HOST_DISC_BIT]);
    ahb(1'h1, ulpi_lpm_pkg::IRQST_ADDR, 32'h00000010);
    ahb(1'h0, ulpi_lpm_pkg::IRQST_ADDR, 32'h0);
    chk("disc cleared", 32'h0, rd[ulpi_lpm_pkg::HOST_DISC_BIT]);
    ahb(1'h1, ulpi_lpm_pkg::CTRL_ADDR, 32'h00000003);
    DISC_SENSE <= 1'h1;
    LONG_EOP <= 1'h1;
    @(posedge MCLK);
    LONG_EOP <= 1'h0;
    DISC_SENSE <= 1'h0;
    count_rx(12);
    chk("rxcmd fs host", 32'h0, n);
    $display("test disconnect done");
    ahb(1'h1, ulpi_lpm_pkg::IRQEN_ADDR, 32'h00000201);
    edges = 0;
    ahb(1'h1, ulpi_lpm_pkg::CTRL_ADDR, 32'h00000006);
    repeat (40) @(posedge MCLK);
    chk("dir entry", 32'h1, DIR);
    chk("edges", 32'h1, edges >= ulpi_lpm_pkg::SUSPEND_EDGES && edges < 12);
    chk("power down", 32'h0, ANALOG_PWR_EN);
    chk("device drives", 32'h1, DATA_OE);
    for (int i = 1; i < 4; i++) begin
      {DMINUS_SE, DPLUS_SE} <= 2'(i);
      repeat (5) @(posedge MCLK);
      chk("line state", 32'(i), DATA_O);
    end
    ahb(1'h0, ulpi_lpm_pkg::STAT_ADDR, 32'h0);
    chk("status", {26'h0, 3'(ulpi_lpm_pkg::ST_LOWPWR), 1'b1, 2'h3}, rd);
    $display("test entry done");
    CMP_IN <= 4'h6;
    repeat (5) @(posedge MCLK);
    chk("masked event", 32'h0, DATA_O[3]);
    CMP_IN <= 4'h4;
    repeat (5) @(posedge MCLK);
    chk("fall event", 32'h1, DATA_O[3]);
    ahb(1'h1, ulpi_lpm_pkg::IRQST_ADDR, 32'h0000000F);
    repeat (2) @(posedge MCLK);
    chk("event cleared", 32'h0, DATA_O[3]);
    CMP_IN <= 4'h5;
    repeat (5) @(posedge MCLK);
    chk("rise event", 32'h1, DATA_O[3]);
    $display("test interrupt done");
    glitch <= 1'h1;
    repeat (2) @(posedge MCLK);
    glitch <= 1'h0;
    repeat (20) @(posedge MCLK);
    chk("false resume", 32'h1, DIR);
    chk("asleep again", 32'h0, ANALOG_PWR_EN);
    tri_en <= 1'h1;
    wait_dir_low();
    chk("pull-up wake", 32'h0, DIR);
    @(posedge MCLK);
    ck = PHY_CLOCK_OUT;
    @(posedge MCLK);
    chk("clock runs", !ck, PHY_CLOCK_OUT);
    tri_en <= 1'h0;
    repeat (4) @(posedge MCLK);
    ahb(1'h0, ulpi_lpm_pkg::CTRL_ADDR, 32'h0);
    chk("phy active set", 32'h1, rd[ulpi_lpm_pkg::PHY_ACTIVE_BIT]);
    $display("test warm wake done");
    ahb(1'h1, ulpi_lpm_pkg::CTRL_ADDR, 32'h00000086);
    repeat (40) @(posedge MCLK);
    chk("asleep", 32'h0, ANALOG_PWR_EN);
    wake <= 1'h1;
    @(posedge MCLK);
    wake <= 1'h0;
    wait_dir_low();
    chk("link wake", 32'h0, DIR);
    repeat (4) @(posedge MCLK);
    ahb(1'h0, ulpi_lpm_pkg::CTRL_ADDR, 32'h0);
    chk("phy active again", 32'h1, rd[ulpi_lpm_pkg::PHY_ACTIVE_BIT]);
    $display("test link wake done");
    test_done();
  end
  initial begin
    repeat (3000) @(posedge MCLK);
    fails++;
    test_done();
  end
endmodule : ulpi_low_power_and_interface_protect_tb_top
bind ulpi_lpm_top ulpi_lpm_checker #(.START_CNT(START_CNT)) ulpi_lpm_checker_i (.*);
`default_nettype wire
